// file: core/bsc_pkg.sv
// boundary-scan constants, state codes and carrier types
// assumes a 5-bit instruction register and a sampled scan port
`default_nettype none

package bsc_pkg;

    localparam int         IR_LEN       = 5;
    localparam logic [4:0] OP_EXTEST    = 5'h00;
    localparam logic [4:0] OP_SAMPLE    = 5'h01;
    localparam logic [4:0] OP_INTERNAL_SCAN_ENABLE_INSTR   = 5'h02;
    localparam logic [4:0] OP_CLAMP     = 5'h04;
    localparam logic [4:0] OP_BYPASS    = 5'h1F;
    localparam logic [4:0] IR_CAPTURE   = 5'h01;
    localparam logic [4:0] IR_RESET_VAL = OP_BYPASS;
    localparam logic       BYP_CAPTURE  = 1'h0;
    localparam logic       CTRL_DRIVE   = 1'h1;
    localparam int         PINS_DEF     = 8;
    localparam int         FIFO_DEPTH   = 32;

    typedef enum logic [15:0] {
        ST_RESET   = 16'h0001,
        ST_IDLE    = 16'h0002,
        ST_SEL_DR  = 16'h0004,
        ST_CAPT_DR = 16'h0008,
        ST_SHFT_DR = 16'h0010,
        ST_EX1_DR  = 16'h0020,
        ST_PAUS_DR = 16'h0040,
        ST_EX2_DR  = 16'h0080,
        ST_UPD_DR  = 16'h0100,
        ST_SEL_IR  = 16'h0200,
        ST_CAPT_IR = 16'h0400,
        ST_SHFT_IR = 16'h0800,
        ST_EX1_IR  = 16'h1000,
        ST_PAUS_IR = 16'h2000,
        ST_EX2_IR  = 16'h4000,
        ST_UPD_IR  = 16'h8000
    } bsc_tap_state_t;

    typedef struct packed {
        logic tck;
        logic tms;
        logic tdi;
    } bsc_scan_port_t;

endpackage : bsc_pkg

`default_nettype wire

// file: core/bsc_scan_port.sv
// boundary-scan test port: tap sequencer, instruction register,
// bypass and boundary registers, pin muxing, snapshot fifo
// assumes tck/tms/tdi and pins are asynchronous to clk_sys_in and
// that tck is much slower than clk_sys_in; fifo depth a power of two
`timescale 1ns/1ns
`default_nettype none

module bsc_snap_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 32
) (
    input  wire logic             clk_in,
    input  wire logic             rst_n_in,
    input  wire logic             in_valid_in,
    input  wire logic [WIDTH-1:0] in_data_in,
    output logic                  in_ready_out,
    output logic                  out_valid_out,
    output logic      [WIDTH-1:0] out_data_out,
    input  wire logic             out_ready_in
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr;
    logic [AW-1:0]    rd_ptr;
    logic [CW-1:0]    count;
    logic [CW-1:0]    next_count;
    logic             push;
    logic             pop;

    assign push = in_valid_in & in_ready_out;
    assign pop  = (count != '0) & (~out_valid_out | out_ready_in);

    always_comb begin
        next_count = count;
        if (push & ~pop) begin
            next_count = count + CW'(1);
        end else if (pop & ~push) begin
            next_count = count - CW'(1);
        end
    end

    always_ff @(posedge clk_in) begin
        if (push) begin
            mem[wr_ptr] <= in_data_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            wr_ptr       <= '0;
            rd_ptr       <= '0;
            count        <= '0;
            in_ready_out <= 1'b1;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + AW'(1);
            end
            if (pop) begin
                rd_ptr <= rd_ptr + AW'(1);
            end
            count        <= next_count;
            in_ready_out <= next_count != CW'(DEPTH);
        end
    end

    // output stage, stalls while the reader holds ready low
    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            out_valid_out <= 1'b0;
            out_data_out  <= '0;
        end else if (pop) begin
            out_valid_out <= 1'b1;
            out_data_out  <= mem[rd_ptr];
        end else if (out_ready_in) begin
            out_valid_out <= 1'b0;
        end
    end
endmodule : bsc_snap_fifo

module bsc_scan_port
    import bsc_pkg::*;
#(
    parameter int NUM_PINS   = PINS_DEF,
    parameter int SNAP_DEPTH = FIFO_DEPTH
) (
    input  wire logic                clk_sys_in,
    input  wire logic                rst_n_in,
    input  wire logic                tck_in,
    input  wire logic                tms_in,
    input  wire logic                tdi_in,
    output logic                     tdo_out,
    output logic                     tdo_oe_out,
    input  wire logic [NUM_PINS-1:0] pin_in,
    output logic      [NUM_PINS-1:0] pin_out,
    output logic      [NUM_PINS-1:0] pin_oe_out,
    input  wire logic [NUM_PINS-1:0] sys_out_in,
    input  wire logic [NUM_PINS-1:0] sys_oe_in,
    output logic      [NUM_PINS-1:0] core_in_out,
    output logic                     internal_scan_enable_instr_out,
    output logic                     snap_valid_out,
    output logic      [NUM_PINS-1:0] snap_data_out,
    input  wire logic                snap_ready_in,
    output logic                     snap_in_ready_out
);
    localparam int BSR_LEN = NUM_PINS + 1;

    bsc_scan_port_t       port_meta;
    bsc_scan_port_t       port_sync;
    logic [NUM_PINS-1:0]  pin_meta;
    logic [NUM_PINS-1:0]  pin_sync;
    logic                 tck_prev;
    logic                 tck_rise;
    logic                 tck_fall;
    bsc_tap_state_t       tap_state;
    bsc_tap_state_t       next_tap_state;
    logic [IR_LEN-1:0]    ir_shift;
    logic [IR_LEN-1:0]    ir_active;
    logic                 bypass_bit;
    logic [BSR_LEN-1:0]   bsr_shift;
    logic [BSR_LEN-1:0]   bsr_upd;
    logic                 is_extest;
    logic                 is_sample;
    logic                 is_clamp;
    logic                 sel_bsr;
    logic                 drive_test;
    logic                 snap_push;

    // two-stage synchronisers; first stage feeds only the second
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            port_meta <= '0;
            port_sync <= '0;
            pin_meta  <= '0;
            pin_sync  <= '0;
            tck_prev  <= 1'b0;
        end else begin
            port_meta <= '{tck: tck_in, tms: tms_in, tdi: tdi_in};
            port_sync <= port_meta;
            pin_meta  <= pin_in;
            pin_sync  <= pin_meta;
            tck_prev  <= port_sync.tck;
        end
    end

    assign tck_rise = port_sync.tck & ~tck_prev;
    assign tck_fall = ~port_sync.tck & tck_prev;

    // instruction decode; anything else falls back to bypass
    assign is_extest  = ir_active == OP_EXTEST;
    assign is_sample  = ir_active == OP_SAMPLE;
    assign is_clamp   = ir_active == OP_CLAMP;
    assign sel_bsr    = is_extest | is_sample;
    assign drive_test = is_extest | is_clamp;

    always_comb begin
        case (tap_state)
            ST_RESET:   next_tap_state = port_sync.tms ? ST_RESET : ST_IDLE;
            ST_IDLE:    next_tap_state = port_sync.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_DR:  next_tap_state = port_sync.tms ? ST_SEL_IR
                                                       : ST_CAPT_DR;
            ST_CAPT_DR: next_tap_state = port_sync.tms ? ST_EX1_DR
                                                       : ST_SHFT_DR;
            ST_SHFT_DR: next_tap_state = port_sync.tms ? ST_EX1_DR
                                                       : ST_SHFT_DR;
            ST_EX1_DR:  next_tap_state = port_sync.tms ? ST_UPD_DR
                                                       : ST_PAUS_DR;
            ST_PAUS_DR: next_tap_state = port_sync.tms ? ST_EX2_DR
                                                       : ST_PAUS_DR;
            ST_EX2_DR:  next_tap_state = port_sync.tms ? ST_UPD_DR
                                                       : ST_SHFT_DR;
            ST_UPD_DR:  next_tap_state = port_sync.tms ? ST_SEL_DR : ST_IDLE;
            ST_SEL_IR:  next_tap_state = port_sync.tms ? ST_RESET
                                                       : ST_CAPT_IR;
            ST_CAPT_IR: next_tap_state = port_sync.tms ? ST_EX1_IR
                                                       : ST_SHFT_IR;
            ST_SHFT_IR: next_tap_state = port_sync.tms ? ST_EX1_IR
                                                       : ST_SHFT_IR;
            ST_EX1_IR:  next_tap_state = port_sync.tms ? ST_UPD_IR
                                                       : ST_PAUS_IR;
            ST_PAUS_IR: next_tap_state = port_sync.tms ? ST_EX2_IR
                                                       : ST_PAUS_IR;
            ST_EX2_IR:  next_tap_state = port_sync.tms ? ST_UPD_IR
                                                       : ST_SHFT_IR;
            ST_UPD_IR:  next_tap_state = port_sync.tms ? ST_SEL_DR : ST_IDLE;
            default:    next_tap_state = ST_RESET;
        endcase
    end

    // sequencer advances on tck rise only
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            tap_state <= ST_RESET;
        end else if (tck_rise) begin
            tap_state <= next_tap_state;
        end
    end

    // instruction register: shift on rise, latch on fall
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            ir_shift  <= IR_CAPTURE;
            ir_active <= IR_RESET_VAL;
        end else begin
            if (tck_rise && tap_state == ST_CAPT_IR) begin
                ir_shift <= IR_CAPTURE;
            end else if (tck_rise && tap_state == ST_SHFT_IR) begin
                ir_shift <= {port_sync.tdi, ir_shift[IR_LEN-1:1]};
            end
            if (tck_fall && tap_state == ST_RESET) begin
                ir_active <= IR_RESET_VAL;
            end else if (tck_fall && tap_state == ST_UPD_IR) begin
                ir_active <= ir_shift;
            end
        end
    end

    // bypass register, used for clamp, bypass and unknown codes
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            bypass_bit <= BYP_CAPTURE;
        end else if (tck_rise && !sel_bsr) begin
            if (tap_state == ST_CAPT_DR) begin
                bypass_bit <= BYP_CAPTURE;
            end else if (tap_state == ST_SHFT_DR) begin
                bypass_bit <= port_sync.tdi;
            end
        end
    end

    // boundary register: control cell at msb, one cell per pin below
    // scan port pins are never part of pin_in / pin_out
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            bsr_shift <= '0;
        end else if (tck_rise && sel_bsr) begin
            if (tap_state == ST_CAPT_DR) begin
                // pin level shows both inputs and driven outputs
                bsr_shift <= {pin_oe_out[0], pin_sync};
            end else if (tap_state == ST_SHFT_DR) begin
                bsr_shift <= {port_sync.tdi, bsr_shift[BSR_LEN-1:1]};
            end
        end
    end

    // update cells move on fall; clamp never touches them
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            bsr_upd <= '0;
        end else if (tck_fall && sel_bsr && tap_state == ST_UPD_DR) begin
            bsr_upd <= bsr_shift;
        end
    end

    // serial output changes on fall, inverted nowhere
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            tdo_out    <= 1'b0;
            tdo_oe_out <= 1'b0;
        end else if (tck_fall) begin
            tdo_oe_out <= (tap_state == ST_SHFT_DR)
                        | (tap_state == ST_SHFT_IR);
            if (tap_state == ST_SHFT_IR) begin
                tdo_out <= ir_shift[0];
            end else if (tap_state == ST_SHFT_DR) begin
                tdo_out <= sel_bsr ? bsr_shift[0] : bypass_bit;
            end
        end
    end

    // pin and core-side muxing; test values only change on tck fall
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            pin_out     <= '0;
            pin_oe_out  <= '0;
            core_in_out <= '0;
            internal_scan_enable_instr_out <= 1'b0;
        end else begin
            if (drive_test) begin
                pin_out    <= bsr_upd[NUM_PINS-1:0];
                pin_oe_out <= {NUM_PINS{bsr_upd[NUM_PINS] == CTRL_DRIVE}};
            end else begin
                pin_out    <= sys_out_in;
                pin_oe_out <= sys_oe_in;
            end
            core_in_out <= is_extest ? bsr_upd[NUM_PINS-1:0]
                                     : pin_sync;
            internal_scan_enable_instr_out <= ir_active == OP_INTERNAL_SCAN_ENABLE_INSTR;
        end
    end

    assign snap_push = tck_rise & sel_bsr & (tap_state == ST_CAPT_DR);

    bsc_snap_fifo #(
        .WIDTH (NUM_PINS),
        .DEPTH (SNAP_DEPTH)
    ) u_snap_fifo (
        .clk_in        (clk_sys_in),
        .rst_n_in      (rst_n_in),
        .in_valid_in   (snap_push),
        .in_data_in    (pin_sync),
        .in_ready_out  (snap_in_ready_out),
        .out_valid_out (snap_valid_out),
        .out_data_out  (snap_data_out),
        .out_ready_in  (snap_ready_in)
    );
endmodule : bsc_scan_port

`default_nettype wire

// file: sim/bsc_scan_port_chk.sv
// checker for bsc_scan_port: tdo, pin and snapshot timing
// bound into each bsc_scan_port; sees its ports only
`timescale 1ns/1ns
`default_nettype none
module bsc_scan_port_chk #(
    parameter int NUM_PINS = 8
) (
    input wire logic                clk_sys_in,
    input wire logic                rst_n_in,
    input wire logic                tck_in,
    input wire logic                tdo_out,
    input wire logic                tdo_oe_out,
    input wire logic [NUM_PINS-1:0] pin_out,
    input wire logic [NUM_PINS-1:0] pin_oe_out,
    input wire logic [NUM_PINS-1:0] sys_out_in,
    input wire logic [NUM_PINS-1:0] sys_oe_in,
    input wire logic                internal_scan_enable_instr_out,
    input wire logic                snap_valid_out,
    input wire logic [NUM_PINS-1:0] snap_data_out,
    input wire logic                snap_ready_in,
    input wire logic                snap_in_ready_out
);
    logic                tck_q;
    logic [3:0]          since_fall;
    logic [NUM_PINS-1:0] out_q, out_qq, oe_q, oe_qq;
    // clocks since tck was last seen falling
    always_ff @(posedge clk_sys_in) begin
        tck_q      <= tck_in;
        since_fall <= (!rst_n_in || (tck_q && !tck_in)) ? 4'h0
                      : since_fall + {3'h0, since_fall != 4'hF};
    end
    // core requests one and two clocks back
    always_ff @(posedge clk_sys_in) begin
        out_q  <= rst_n_in ? sys_out_in : '0;
        oe_q   <= rst_n_in ? sys_oe_in : '0;
        out_qq <= out_q;
        oe_qq  <= oe_q;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_fall_win;
        since_fall inside {[4'h2:4'h5]};
    endsequence
    sequence s_stall;
        snap_valid_out && !snap_ready_in;
    endsequence
    a_tdo_at_fall: assert property ($changed(tdo_out) |-> s_fall_win)
        else $error("tdo moved away from a tck fall");
    a_tdo_oe_fall: assert property ($changed(tdo_oe_out) |-> s_fall_win)
        else $error("tdo enable moved away from a tck fall");
    a_pin_out_cause: assert property (
        $changed(pin_out) && out_q == out_qq |-> s_fall_win)
        else $error("pin value moved without cause");
    a_pin_oe_cause: assert property (
        $changed(pin_oe_out) && oe_q == oe_qq |-> s_fall_win)
        else $error("pin enable moved without cause");
    a_scan_en_fall: assert property (
        $changed(internal_scan_enable_instr_out) |-> s_fall_win)
        else $error("scan enable moved away from a tck fall");
    a_snap_hold: assert property (
        s_stall |=> snap_valid_out && $stable(snap_data_out))
        else $error("snapshot word dropped while stalled");
    a_full_has_data: assert property (
        !snap_in_ready_out |-> snap_valid_out)
        else $error("fifo full with no word offered");
    a_reset_quiet: assert property ($rose(rst_n_in) |-> !tdo_out &&
        !tdo_oe_out && pin_oe_out == '0 && !snap_valid_out && snap_in_ready_out)
        else $error("outputs not quiet out of reset");
endmodule : bsc_scan_port_chk
bind bsc_scan_port bsc_scan_port_chk #(.NUM_PINS(NUM_PINS)) u_chk (
    .clk_sys_in, .rst_n_in, .tck_in, .tdo_out, .tdo_oe_out, .pin_out,
    .pin_oe_out, .sys_out_in, .sys_oe_in, .internal_scan_enable_instr_out,
    .snap_valid_out, .snap_data_out, .snap_ready_in, .snap_in_ready_out);
`default_nettype wire

// file: sim/bsc_tester_model.sv
// scan tester model: drives tck, tms and tdi, reads tdo
// assumes clk_in of 100 ns; tck held 5 clocks low, 3 high
`timescale 1ns/1ns
`default_nettype none
module bsc_tester_model
    import bsc_pkg::*;
(
    input  wire logic           clk_in,
    input  wire logic           tdo_in,
    output var  bsc_scan_port_t port_out
);
    initial port_out = '0;
    // one tck period; tdo read just ahead of the rise
    task automatic step(input logic m, input logic d, output logic o);
        port_out.tms <= m;
        port_out.tdi <= d;
        repeat (5) @(posedge clk_in);
        o = tdo_in;
        port_out.tck <= 1'h1;
        repeat (3) @(posedge clk_in);
        port_out.tck <= 1'h0;
    endtask : step
    task automatic reset_tap();
        logic o;
        repeat (5) step(1'h1, 1'h0, o);
        step(1'h0, 1'h0, o);
    endtask : reset_tap
    // idle to idle through one ir or dr scan, lsb first
    task automatic scan(input logic ir, input int n,
                        input logic [15:0] din, output logic [15:0] dout);
        logic o;
        dout = '0;
        step(1'h1, 1'h0, o);
        if (ir) step(1'h1, 1'h0, o);
        step(1'h0, 1'h0, o);
        step(1'h0, 1'h0, o);
        for (int i = 0; i < n; i++) begin
            step(i == n - 1, din[i], o);
            dout[i] = o;
        end
        step(1'h1, 1'h0, o);
        step(1'h0, 1'h0, o);
    endtask : scan
endmodule : bsc_tester_model
`default_nettype wire

// file: sim/bsc_scan_port_tb.sv
// testbench for bsc_scan_port: pin model and snapshot queue
// assumes bsc_tester_model on the scan link and eight pins
`timescale 1ns/1ns
`default_nettype none
module bsc_scan_port_tb
    import bsc_pkg::*;
;
    localparam int  N = 8;
    localparam int  TCK_CLKS = 8;
    logic           clk = 1'h0;
    logic           rst_n = 1'h0;
    logic           snap_ready = 1'h0;
    logic           ctrl = 1'h0;
    logic [N-1:0]   pin_in = '0;
    logic [N-1:0]   sys_out = '0;
    logic [N-1:0]   sys_oe = '0;
    logic [N-1:0]   pin_out, pin_oe, core_in, snap_data;
    logic           tdo, tdo_oe, scan_en, snap_valid, snap_in_ready;
    logic [15:0]    d;
    logic [N-1:0]   q[$];
    logic [4:0]     codes[6] = '{OP_BYPASS, OP_INTERNAL_SCAN_ENABLE_INSTR, 5'h03, 5'h08,
                                 5'h15, 5'h1E};
    bsc_scan_port_t link;
    int             fails = 0;
    int             compares = 0;
    int             cycles = 0;
    int             oe_cycles = 0;
    int             seed = 13;
    always #50 clk = ~clk;
    bsc_scan_port #(.NUM_PINS(N), .SNAP_DEPTH(FIFO_DEPTH)) u_dut (
        .clk_sys_in(clk), .rst_n_in(rst_n), .tck_in(link.tck),
        .tms_in(link.tms), .tdi_in(link.tdi), .tdo_out(tdo),
        .tdo_oe_out(tdo_oe), .pin_in(pin_in), .pin_out(pin_out),
        .pin_oe_out(pin_oe), .sys_out_in(sys_out), .sys_oe_in(sys_oe),
        .core_in_out(core_in), .internal_scan_enable_instr_out(scan_en),
        .snap_valid_out(snap_valid), .snap_data_out(snap_data),
        .snap_ready_in(snap_ready), .snap_in_ready_out(snap_in_ready));
    bsc_tester_model u_tester (.clk_in(clk), .tdo_in(tdo), .port_out(link));
    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        compares++;
        if (got !== exp) begin
            fails++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask : check
    task automatic complete_run();
        if (fails == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : complete_run
    task automatic new_pins();
        pin_in  <= N'($random(seed));
        sys_out <= N'($random(seed));
        sys_oe  <= N'($random(seed));
        repeat (3) @(posedge clk);
    endtask : new_pins
    task automatic pins(input logic [N-1:0] eo, input logic [N-1:0] eoe);
        repeat (2) @(posedge clk);
        check("pin_out", 16'(eo), 16'(pin_out));
        check("pin_oe", 16'(eoe), 16'(pin_oe));
    endtask : pins
    task automatic load_ir(input logic [4:0] code);
        u_tester.scan(1'h1, IR_LEN, 16'(code), d);
        check("ir_capture", 16'(IR_CAPTURE), d);
    endtask : load_ir
    task automatic byp_dr();
        logic [N-1:0] v;
        int           oe0;
        v = N'($random(seed));
        oe0 = oe_cycles;
        u_tester.scan(1'h0, N, 16'(v), d);
        check("bypass_out", 16'({v[N-2:0], BYP_CAPTURE}), d);
        check("tdo_oe_len", 16'(TCK_CLKS * N), 16'(oe_cycles - oe0));
    endtask : byp_dr
    // capture {control cell, pins}, then shift in load and update
    task automatic bound_dr(input logic smp, input logic [N:0] load);
        logic cap;
        new_pins();
        cap = smp ? sys_oe[0] : ctrl;
        u_tester.scan(1'h0, N + 1, 16'(load), d);
        check("capture", 16'({cap, pin_in}), d);
        // fifo words plus the output stage
        if (q.size() < FIFO_DEPTH + 1) q.push_back(pin_in);
        ctrl = load[N];
    endtask : bound_dr
    always @(posedge clk) begin
        cycles++;
        if (tdo_oe === 1'h1) oe_cycles++;
        if (cycles == 15000) begin
            fails++;
            complete_run();
        end
    end
    initial begin
        logic [N:0] load;
        repeat (5) @(posedge clk);
        rst_n <= 1'h1;
        repeat (4) @(posedge clk);
        u_tester.reset_tap();
        byp_dr();
        for (int k = 0; k < 6; k++) begin
            load_ir(codes[k]);
            new_pins();
            byp_dr();
            pins(sys_out, sys_oe);
            check("scan_en", 16'(codes[k] == OP_INTERNAL_SCAN_ENABLE_INSTR), 16'(scan_en));
        end
        load_ir(OP_SAMPLE);
        load = {1'h1, N'($random(seed))};
        bound_dr(1'h1, load);
        pins(sys_out, sys_oe);
        check("core_in", 16'(pin_in), 16'(core_in));
        load_ir(OP_EXTEST);
        pins(load[N-1:0], {N{load[N]}});
        for (int k = 0; k < 2; k++) begin
            load = {k[0], N'($random(seed))};
            bound_dr(1'h0, load);
            pins(load[N-1:0], {N{load[N]}});
            check("core_in", 16'(load[N-1:0]), 16'(core_in));
        end
        load_ir(OP_CLAMP);
        new_pins();
        byp_dr();
        pins(load[N-1:0], {N{load[N]}});
        u_tester.reset_tap();
        new_pins();
        pins(sys_out, sys_oe);
        load_ir(OP_SAMPLE);
        for (int k = 0; k < 31; k++) begin
            bound_dr(1'h1, {1'h1, N'($random(seed))});
        end
        check("snap_room", 16'h0, 16'(snap_in_ready));
        repeat (300) begin
            @(posedge clk);
            if (snap_valid === 1'h1 && snap_ready === 1'h1 && q.size() > 0)
                check("snap_data", 16'(q.pop_front()), 16'(snap_data));
            snap_ready <= 1'($random(seed));
        end
        check("snap_left", 16'h0, 16'(q.size()));
        check("snap_valid", 16'h0, 16'(snap_valid));
        complete_run();
    end
endmodule : bsc_scan_port_tb
`default_nettype wire
